// [core/timer2_pkg.sv]
package timer2_pkg;
  localparam int ADDR_W   = 12;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W    = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT_LOW = 8'h09;
  localparam logic [7:0] IDX_TIMER_CTRL_ONE  = 8'h0A;
  localparam logic [7:0] IDX_TIMER_CTRL_TWO  = 8'h0B;
  localparam logic [7:0] IDX_PWM_DUTY_LOW    = 8'h0C;
  localparam logic [7:0] IDX_PRESCALER_COUNT = 8'h0D;
  localparam logic [7:0] IDX_TONE_CTRL       = 8'h0E;
  localparam logic [7:0] IDX_SHARED_HIGH     = 8'h1F;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h3F;
  localparam logic [7:0] TONE_CTRL_RST = 8'h0F;
  localparam logic [7:0] SHARED_RST    = 8'h00;
  localparam logic [7:0] DUTY_RST      = 8'h00;
  localparam logic [7:0] RELOAD_RST    = 8'h00;
  localparam logic [7:0] PRESCALER_RST = 8'hFF;
  localparam logic [7:0] CTRL_ONE_MASK = 8'hCF;
  localparam logic [7:0] CTRL_TWO_MASK = 8'h3F;
  localparam logic [7:0] TONE_MASK     = 8'h8F;
  localparam logic [9:0] TIMER_FULL    = 10'h3FF;
  localparam logic [9:0] TIMER_ZERO    = 10'h000;
  localparam int CT1_PWM_OE   = 7;
  localparam int CT1_PWM_AL   = 6;
  localparam int CT1_FAST     = 3;
  localparam int CT1_ONE_SHOT = 2;
  localparam int CT1_RELOAD   = 1;
  localparam int CT1_ENABLE   = 0;
  localparam int CT2_SOURCE   = 5;
  localparam int CT2_EDGE     = 4;
  localparam int CT2_PS_DIS_N = 3;
  localparam int CT2_RATE_LSB = 0;
  localparam int RATE_W       = 3;
  localparam int TONE_EN      = 7;
  localparam int TONE_SEL_LSB = 0;
  localparam int TONE_SEL_W   = 4;
  localparam int TONE_TIMER   = 3;
  localparam int SH_RELOAD    = 6;
  localparam int SH_DUTY      = 2;
  localparam int HI_W         = 2;
endpackage

// [core/rate_prescaler.sv]
`timescale 1ns/100ps
`default_nettype none
module rate_prescaler
  import timer2_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int SEL_W = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic             src_tick,
  input  wire logic [SEL_W-1:0] rate_select,
  output logic      [WIDTH-1:0] count,
  output logic                  tick
);
  logic [WIDTH-1:0] mask;
  logic [SEL_W:0]   shift;

  if ((1 << SEL_W) != WIDTH) begin : g_check
    $error("prescaler width must equal two to the select width");
  end

  // a divide by 2^(code+1) fires when the low code+1 bits of the down count are zero
  always_comb begin
    shift = {1'b0, rate_select} + {{SEL_W{1'b0}}, 1'b1};
    mask  = ~({WIDTH{1'b1}} << shift);
    tick  = enable && src_tick && ((count & mask) == '0);
  end

  // holds while disabled
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count <= PRESCALER_RST;
    end else if (enable && src_tick) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [core/down_counter10.sv]
`timescale 1ns/100ps
`default_nettype none
module down_counter10
  import timer2_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic             one_shot,
  input  wire logic             reload_sel,
  input  wire logic [WIDTH-1:0] reload_value,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count,
  output logic                  stopped
);
  if (WIDTH != 10) begin : g_check
    $error("timer width must be 10");
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count   <= TIMER_ZERO;
      stopped <= 1'b0;
    end else if (load) begin
      count   <= load_value;
      stopped <= 1'b0;
    end else if (run && tick && !stopped) begin
      if (count == TIMER_ZERO) begin
        if (one_shot) begin
          stopped <= 1'b1;
        end else begin
          count <= reload_sel ? reload_value : TIMER_FULL;
        end
      end else begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// [core/timer2_top.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - The prescaler divides the chosen clock by 2 for rate code 000, doubling per code up to 256 at 111.
// - With the edge bit at 1 the timer counts falling input transitions, at 0 rising ones.
// - The source bit at 1 routes the external count input, at 0 the instruction or fast clock.
// - With the reload bit at 1 the PWM frame period is the 10-bit reload value made of two shared high bits and the low reload byte, at 0 it is 0x3FF.
// - The PWM duty is a 10-bit value made of shared high bits 3 to 2 and the write-only duty byte.
// - The prescaler count register reads the live count, is read-only and resets to all ones.
// - Tone codes 0000 to 0111 give inverted prescaler count bits 0 to 7, the chosen clock divided by 2 to 256, driven only while enabled.
// - Tone codes 1000 to 1111 give timer bits 0 to 7, and the code resets to 1111.
// - The timer counts down to zero, stops there in one-shot mode, else reloads the reload value or 0x3FF.
// - The PWM output is active low when the polarity bit is 1 and active high when it is 0.
// - The fast clock select bit clocks timer and PWM from the fast oscillator regardless of the source bit.
module timer2_top
  import timer2_pkg::*;
#(
  parameter int TIMER_W = 10,
  parameter int PS_W    = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_tick,
  input  wire logic              fast_osc_tick,
  input  wire logic              ext_count_input,
  output logic                   pwm_out,
  output logic                   pwm_oe,
  output logic                   tone_out,
  output logic                   tone_oe
);
  logic [7:0]         timer_ctrl_one;
  logic [7:0]         timer_ctrl_two;
  logic [7:0]         pwm_duty_low;
  logic [7:0]         tone_ctrl;
  logic [7:0]         shared_high_bits;
  logic [7:0]         reload_low;
  logic [IDX_W-1:0]   index;
  logic               aligned;
  logic               mapped;
  logic               wr_en;
  logic               timer_load;
  logic [TIMER_W-1:0] load_value;
  logic [TIMER_W-1:0] reload_value;
  logic [TIMER_W-1:0] duty_value;
  logic [TIMER_W-1:0] timer_count;
  logic               timer_stopped;
  logic [PS_W-1:0]    ps_count;
  logic               ps_tick;
  logic               ps_enable;
  logic               ext_prev;
  logic               ext_edge;
  logic               base_tick;
  logic               timer_tick;
  logic               fast_clock_select;
  logic               ext_edge_select;
  logic               timer_clock_source_select;
  logic               one_shot_select;
  logic               reload_select;
  logic               pwm_active_low;
  logic               tone_output_enable;
  logic [3:0]         tone_freq_select;
  logic               next_pwm_out;
  logic               next_tone;
  logic [31:0]        next_prdata;
  logic               next_err;

  if (TIMER_W != 10 || PS_W != 8) begin : g_check
    $error("timer must be 10 bits and prescaler 8 bits");
  end

  // control fields
  always_comb begin
    fast_clock_select         = timer_ctrl_one[CT1_FAST];
    one_shot_select           = timer_ctrl_one[CT1_ONE_SHOT];
    reload_select             = timer_ctrl_one[CT1_RELOAD];
    pwm_active_low            = timer_ctrl_one[CT1_PWM_AL];
    ext_edge_select           = timer_ctrl_two[CT2_EDGE];
    timer_clock_source_select = timer_ctrl_two[CT2_SOURCE];
    ps_enable                 = !timer_ctrl_two[CT2_PS_DIS_N];
    tone_output_enable        = tone_ctrl[TONE_EN];
    tone_freq_select          = tone_ctrl[TONE_SEL_LSB +: TONE_SEL_W];
    reload_value = {shared_high_bits[SH_RELOAD +: HI_W], reload_low};
    duty_value   = {shared_high_bits[SH_DUTY +: HI_W], pwm_duty_low};
  end

  // apb decode
  always_comb begin
    index   = paddr[ADDR_LSB +: IDX_W];
    aligned = (paddr[ADDR_LSB-1:0] == '0) && (paddr[ADDR_W-1:ADDR_LSB+IDX_W] == '0);
    if (!aligned) begin
      mapped = 1'b0;
    end else if (index == IDX_TIMER_COUNT_LOW || index == IDX_TIMER_CTRL_ONE) begin
      mapped = 1'b1;
    end else if (index == IDX_TIMER_CTRL_TWO || index == IDX_PWM_DUTY_LOW) begin
      mapped = 1'b1;
    end else if (index == IDX_PRESCALER_COUNT || index == IDX_TONE_CTRL) begin
      mapped = 1'b1;
    end else if (index == IDX_SHARED_HIGH) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
    wr_en      = psel && penable && pready && pwrite && mapped;
    timer_load = wr_en && (index == IDX_TIMER_COUNT_LOW);
    load_value = {shared_high_bits[SH_RELOAD +: HI_W], pwdata[7:0]};
  end

  // read data is captured in the setup cycle; write-only registers read zero
  always_comb begin
    next_prdata = '0;
    next_err    = !mapped;
    if (index == IDX_TIMER_COUNT_LOW) begin
      next_prdata[7:0] = timer_count[7:0];
    end else if (index == IDX_TIMER_CTRL_ONE) begin
      next_prdata[7:0] = timer_ctrl_one;
    end else if (index == IDX_TIMER_CTRL_TWO) begin
      next_prdata[7:0] = timer_ctrl_two;
    end else if (index == IDX_PRESCALER_COUNT) begin
      next_prdata[7:0] = ps_count;
    end else if (index == IDX_SHARED_HIGH) begin
      next_prdata[7:0] = shared_high_bits;
    end
  end

  // no wait state: pready rises in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= next_err;
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
        prdata  <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timer_ctrl_one   <= CTRL_ONE_RST;
      timer_ctrl_two   <= CTRL_TWO_RST;
      pwm_duty_low     <= DUTY_RST;
      tone_ctrl        <= TONE_CTRL_RST;
      shared_high_bits <= SHARED_RST;
      reload_low       <= RELOAD_RST;
    end else if (wr_en) begin
      if (index == IDX_TIMER_COUNT_LOW) begin
        reload_low <= pwdata[7:0];
      end else if (index == IDX_TIMER_CTRL_ONE) begin
        timer_ctrl_one <= pwdata[7:0] & CTRL_ONE_MASK;
      end else if (index == IDX_TIMER_CTRL_TWO) begin
        timer_ctrl_two <= pwdata[7:0] & CTRL_TWO_MASK;
      end else if (index == IDX_PWM_DUTY_LOW) begin
        pwm_duty_low <= pwdata[7:0];
      end else if (index == IDX_TONE_CTRL) begin
        tone_ctrl <= pwdata[7:0] & TONE_MASK;
      end else if (index == IDX_SHARED_HIGH) begin
        shared_high_bits <= pwdata[7:0];
      end
    end
  end

  // count clock selection
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // tracks the pin during reset so an idle-high pin gives no false edge after release
      ext_prev <= ext_count_input;
    end else begin
      ext_prev <= ext_count_input;
    end
  end

  always_comb begin
    ext_edge = ext_edge_select ? (ext_prev && !ext_count_input)
                               : (!ext_prev && ext_count_input);
    if (fast_clock_select) begin
      base_tick = fast_osc_tick;
    end else if (timer_clock_source_select) begin
      base_tick = ext_edge;
    end else begin
      base_tick = instr_tick;
    end
    timer_tick = ps_enable ? ps_tick : base_tick;
  end

  rate_prescaler #(
    .WIDTH(PS_W),
    .SEL_W(RATE_W)
  ) u_prescaler (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .enable     (ps_enable),
    .src_tick   (base_tick),
    .rate_select(timer_ctrl_two[CT2_RATE_LSB +: RATE_W]),
    .count      (ps_count),
    .tick       (ps_tick)
  );

  down_counter10 #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .run         (timer_ctrl_one[CT1_ENABLE]),
    .tick        (timer_tick),
    .one_shot    (one_shot_select),
    .reload_sel  (reload_select),
    .reload_value(reload_value),
    .load        (timer_load),
    .load_value  (load_value),
    .count       (timer_count),
    .stopped     (timer_stopped)
  );

  // pwm is active while the count is below the duty value
  always_comb begin
    if (timer_ctrl_one[CT1_PWM_OE] && timer_ctrl_one[CT1_ENABLE]) begin
      next_pwm_out = (timer_count < duty_value) ^ pwm_active_low;
    end else begin
      next_pwm_out = pwm_active_low;
    end
    if (tone_freq_select[TONE_TIMER]) begin
      next_tone = timer_count[tone_freq_select[2:0]];
    end else begin
      next_tone = !ps_count[tone_freq_select[2:0]];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pwm_out  <= 1'b0;
      pwm_oe   <= 1'b0;
      tone_out <= 1'b0;
      tone_oe  <= 1'b0;
    end else begin
      pwm_out  <= next_pwm_out;
      pwm_oe   <= timer_ctrl_one[CT1_PWM_OE];
      tone_out <= tone_output_enable && next_tone;
      tone_oe  <= tone_output_enable;
    end
  end

  logic count_free;
  logic [PS_W-1:0] ps_mask;
  assign count_free = timer_ctrl_one[CT1_ENABLE] && !timer_stopped && !timer_load;
  assign ps_mask    = ~({PS_W{1'b1}} << ({1'b0, timer_ctrl_two[CT2_RATE_LSB +: RATE_W]} + 4'h1));

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_rate_divide: assert property (
    ps_tick |-> ps_enable && base_tick && ((ps_count & ps_mask) == '0))
    else $error("prescaler tick off its divide boundary");

  a_bypass_hold: assert property (
    !ps_enable |=> ps_count == $past(ps_count))
    else $error("prescaler count moved while disabled");

  a_bypass_pass: assert property (
    !ps_enable && base_tick && count_free && timer_count != TIMER_ZERO
      |=> timer_count == $past(timer_count) - 10'h001)
    else $error("bypassed tick did not reach the timer");

  a_ext_edge_count: assert property (
    !fast_clock_select && timer_clock_source_select && !ps_enable && count_free
      && timer_count != TIMER_ZERO
      && (ext_edge_select ? $fell(ext_count_input) : $rose(ext_count_input))
      |=> timer_count == $past(timer_count) - 10'h001)
    else $error("external edge did not decrement the timer");

  a_fast_override: assert property (
    fast_clock_select && !ps_enable && !fast_osc_tick
      |=> timer_count == $past(timer_count) || $past(timer_load))
    else $error("timer moved without a fast oscillator tick");

  a_one_shot_stop: assert property (
    one_shot_select && timer_tick && count_free && timer_count == TIMER_ZERO
      |=> timer_stopped ##1 (timer_count == TIMER_ZERO || $past(timer_load)))
    else $error("one-shot timer did not stop at zero");

  a_reload_value: assert property (
    !one_shot_select && timer_tick && count_free && timer_count == TIMER_ZERO
      |=> timer_count == ($past(reload_select) ? $past(reload_value) : TIMER_FULL))
    else $error("wrong reload after underflow");

  a_psc_read: assert property (
    psel && penable && pready && !pwrite && index == IDX_PRESCALER_COUNT
      |-> prdata[7:0] == $past(ps_count) && prdata[31:8] == '0)
    else $error("prescaler count read mismatch");

  a_psc_reset: assert property (
    $rose(reset_n) |-> ps_count == PRESCALER_RST)
    else $error("prescaler count not all ones after reset");

  a_pwm_polarity: assert property (
    timer_ctrl_one[CT1_PWM_OE] && timer_ctrl_one[CT1_ENABLE] && timer_count < duty_value
      |=> pwm_out == !$past(pwm_active_low))
    else $error("pwm active level wrong");

  a_tone_gate: assert property (
    !tone_output_enable |=> !tone_out && !tone_oe)
    else $error("tone driven while disabled");

  a_tone_timer: assert property (
    tone_output_enable && tone_freq_select[TONE_TIMER] && timer_count[tone_freq_select[2:0]]
      |=> tone_out)
    else $error("tone does not follow a set timer bit");

  a_tone_timer_low: assert property (
    tone_output_enable && tone_freq_select[TONE_TIMER] && !timer_count[tone_freq_select[2:0]]
      |=> !tone_out)
    else $error("tone does not follow a clear timer bit");

  a_tone_prescaler: assert property (
    tone_output_enable && !tone_freq_select[TONE_TIMER] && !ps_count[tone_freq_select[2:0]]
      |=> tone_out)
    else $error("tone does not follow the prescaler tap");

  a_pwm_idle: assert property (
    !(timer_ctrl_one[CT1_PWM_OE] && timer_ctrl_one[CT1_ENABLE])
      |=> pwm_out == $past(pwm_active_low))
    else $error("pwm not at its inactive level while off");

  a_duty_inactive: assert property (
    timer_ctrl_one[CT1_PWM_OE] && timer_ctrl_one[CT1_ENABLE] && timer_count >= duty_value
      |=> pwm_out == $past(pwm_active_low))
    else $error("pwm active at or above the duty value");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  c_one_shot: cover property (one_shot_select && timer_stopped);
  c_ext_count: cover property (timer_clock_source_select && ext_edge && count_free);
  c_tone_on: cover property (tone_output_enable && tone_out);
  c_pwm_frame: cover property (pwm_oe && $rose(pwm_out));
  c_reload: cover property (!one_shot_select && timer_tick && count_free && timer_count == TIMER_ZERO);
endmodule
`default_nettype wire

// [verif/timer2_prescaler_pwm_buzzer_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module timer2_prescaler_pwm_buzzer_bench
  import timer2_pkg::*;
;
  typedef struct packed {logic rd; logic err; logic [7:0] d;} note_t;
  logic              ref_clk;
  logic              reset_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              instr_tick;
  logic              fast_osc_tick;
  logic              ext_count_input;
  logic              pwm_out;
  logic              pwm_oe;
  logic              tone_out;
  logic              tone_oe;
  int                n_mismatch;
  int                tests_run;
  note_t             notes[$];
  note_t             seen_note;
  logic [31:0]       rnd;
  logic [7:0]        ps;
  logic [7:0]        v;
  logic [7:0]        sh [4] = '{8'h00, 8'h00, 8'h04, 8'h44};
  logic [7:0]        du [4] = '{8'h51, 8'h50, 8'h00, 8'h40};
  logic              act [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  timer2_top u_dut (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .instr_tick      (instr_tick),
    .fast_osc_tick   (fast_osc_tick),
    .ext_count_input (ext_count_input),
    .pwm_out         (pwm_out),
    .pwm_oe          (pwm_oe),
    .tone_out        (tone_out),
    .tone_oe         (tone_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; the expected answer goes to the note queue first
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d, input logic [7:0] e,
                     input logic err);
    int k;
    notes.push_back({~w & ~err, err, e});
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(idx, 1'b0, 8'h00, e, 1'b0);
  endtask

  // which: 0 instruction tick, 1 fast oscillator tick, 2 external pin pulse
  task automatic pulses(input int which, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (which == 0) instr_tick <= 1'b1;
      else if (which == 1) fast_osc_tick <= 1'b1;
      else ext_count_input <= 1'b1;
      @(posedge ref_clk);
      instr_tick      <= 1'b0;
      fast_osc_tick   <= 1'b0;
      ext_count_input <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("note queue", 32'h00000001, 32'h00000000);
      end else begin
        seen_note = notes.pop_front();
        check("pslverr", {31'h00000000, pslverr}, {31'h00000000, seen_note.err});
        if (seen_note.rd) check("prdata", prdata, {24'h000000, seen_note.d});
      end
    end
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    instr_tick = 1'b0; fast_osc_tick = 1'b0; ext_count_input = 1'b0;
    n_mismatch = 0; tests_run = 0; rnd = 32'h00001A32; ps = 8'hFF;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(IDX_TIMER_CTRL_TWO, 8'h3F);
    rd(IDX_PRESCALER_COUNT, 8'hFF);
    rd(IDX_TONE_CTRL, 8'h00);
    rd(IDX_PWM_DUTY_LOW, 8'h00);
    apb(8'h20, 1'b0, 8'h00, 8'h00, 1'b1);
    wr(IDX_PRESCALER_COUNT, 8'h00);
    rd(IDX_PRESCALER_COUNT, 8'hFF);
    wr(IDX_TIMER_CTRL_ONE, 8'h01);
    // descending rates keep the prescaler aligned to each new divide ratio
    for (int r = 7; r >= 0; r--) begin
      // disable first with the old rate, then change the rate
      wr(IDX_TIMER_CTRL_TWO, 8'h08 | 8'((r == 7) ? 7 : r + 1));
      wr(IDX_TIMER_CTRL_TWO, {5'b00001, 3'(r)});
      wr(IDX_TIMER_CTRL_TWO, {5'b00000, 3'(r)});
      wr(IDX_TIMER_COUNT_LOW, 8'hC8);
      pulses(0, 2 << (r + 1));
      ps = ps - 8'((2 << (r + 1)) & 255);
      rd(IDX_TIMER_COUNT_LOW, 8'hC6);
      rd(IDX_PRESCALER_COUNT, ps);
    end
    wr(IDX_TIMER_CTRL_TWO, 8'h08);
    wr(IDX_TIMER_COUNT_LOW, 8'h40);
    pulses(0, 5);
    rd(IDX_TIMER_COUNT_LOW, 8'h3B);
    rd(IDX_PRESCALER_COUNT, ps);
    wr(IDX_TIMER_CTRL_TWO, 8'h28);
    wr(IDX_TIMER_CTRL_ONE, 8'h09);
    wr(IDX_TIMER_COUNT_LOW, 8'h40);
    pulses(1, 6);
    pulses(0, 3);
    pulses(2, 2);
    rd(IDX_TIMER_COUNT_LOW, 8'h3A);
    wr(IDX_TIMER_CTRL_ONE, 8'h01);
    wr(IDX_TIMER_COUNT_LOW, 8'h40);
    pulses(2, 4);
    pulses(0, 3);
    rd(IDX_TIMER_COUNT_LOW, 8'h3C);
    wr(IDX_TIMER_CTRL_TWO, 8'h38);
    wr(IDX_TIMER_COUNT_LOW, 8'h40);
    pulses(2, 4);
    rd(IDX_TIMER_COUNT_LOW, 8'h3C);
    wr(IDX_TIMER_CTRL_TWO, 8'h08);
    wr(IDX_TIMER_COUNT_LOW, 8'h03);
    pulses(0, 4);
    rd(IDX_TIMER_COUNT_LOW, 8'hFF);
    wr(IDX_TIMER_CTRL_ONE, 8'h03);
    wr(IDX_TIMER_COUNT_LOW, 8'h03);
    pulses(0, 4);
    rd(IDX_TIMER_COUNT_LOW, 8'h03);
    wr(IDX_TIMER_CTRL_ONE, 8'h05);
    wr(IDX_TIMER_COUNT_LOW, 8'h02);
    pulses(0, 5);
    rd(IDX_TIMER_COUNT_LOW, 8'h00);
    rnd = xs(rnd);
    v = rnd[7:0];
    wr(IDX_TIMER_CTRL_ONE, 8'h01);
    wr(IDX_TIMER_COUNT_LOW, v);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_TONE_CTRL, 8'h80 | 8'(c));
      settle();
      if (c < 8) check("tone prescaler tap", {31'h00000000, tone_out}, {31'h00000000, ~ps[c]});
      else check("tone timer bit", {31'h00000000, tone_out}, {31'h00000000, v[c-8]});
      check("tone_oe", {31'h00000000, tone_oe}, 32'h00000001);
    end
    wr(IDX_TONE_CTRL, 8'h0F);
    settle();
    check("tone off", {30'h00000000, tone_oe, tone_out}, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SHARED_HIGH, sh[i]);
      wr(IDX_TIMER_COUNT_LOW, 8'h50);
      wr(IDX_PWM_DUTY_LOW, du[i]);
      for (int p = 0; p < 2; p++) begin
        wr(IDX_TIMER_CTRL_ONE, {1'b1, 1'(p), 6'h01});
        settle();
        check("pwm_out", {31'h00000000, pwm_out}, {31'h00000000, act[i] ^ 1'(p)});
        check("pwm_oe", {31'h00000000, pwm_oe}, 32'h00000001);
      end
    end
    wr(IDX_TIMER_CTRL_ONE, 8'h41);
    settle();
    check("pwm idle", {30'h00000000, pwm_oe, pwm_out}, 32'h00000001);
    report_and_stop();
  end
endmodule
`default_nettype wire
